// [pkg/sor_pkg.sv]
// Package with register numbers, frame places and timing for the output block
package sor_pkg;
  localparam int unsigned CHANNELS      = 16;
  localparam int unsigned BYTE_W        = 8;
  // Acyclic register numbers
  localparam logic [7:0]  REG_SWITCH_LO = 8'h02;
  localparam logic [7:0]  REG_SWITCH_HI = 8'h03;
  localparam logic [7:0]  REG_FAULT_LO  = 8'h1E;
  localparam logic [7:0]  REG_FAULT_HI  = 8'h1F;
  // Cyclic frame places, standard model
  localparam logic [1:0]  STD_POS_SW_LO = 2'h0;
  localparam logic [1:0]  STD_POS_SW_HI = 2'h1;
  localparam logic [1:0]  STD_POS_FT_LO = 2'h2;
  localparam logic [1:0]  STD_POS_FT_HI = 2'h3;
  // Byte places inside the CAN object, bus-controller model
  localparam logic [1:0]  BC_POS_SW_LO  = 2'h0;
  localparam logic [1:0]  BC_POS_SW_HI  = 2'h1;
  localparam int unsigned BC_SLOTS      = 2;
  // Function model codes
  localparam logic [7:0]  MODEL_STD     = 8'h00;
  localparam logic [7:0]  MODEL_BC      = 8'hFE;
  // Reset values
  localparam logic [15:0] SWITCH_RST    = 16'h0000;
  localparam logic [15:0] FAULT_RST     = 16'h0000;
  // Sync-to-output delay, must stay below 60 us
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned APPLY_DLY_NS  = 1000;
  localparam int unsigned APPLY_CYC     =
    (APPLY_DLY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned MAX_DLY_NS    = 60000;
endpackage : sor_pkg

// [core/sor_channel.sv]
// One output channel: drive level and mismatch monitor
`timescale 1ns/1ps
module sor_channel
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic apply_i,
  input  wire logic cmd_i,
  input  wire logic sense_i,
  // Results
  output logic      drive_o,
  output logic      fault_o
);
  logic drive_q, drive_d;
  logic fault_q, fault_d;
  logic blank_q, blank_d;

  always_comb
  begin
    drive_d = drive_q;
    fault_d = fault_q;
    blank_d = 1'b0;
    if (apply_i && (cmd_i != drive_q))
    begin
      drive_d = cmd_i;
      fault_d = 1'b0;
      blank_d = 1'b1;
    end
    else if (!blank_q)
    begin
      // Skip one cycle after a switch so the sense can settle
      fault_d = (sense_i != drive_q);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      drive_q <= 1'b0;
      fault_q <= 1'b0;
      blank_q <= 1'b0;
    end
    else
    begin
      drive_q <= drive_d;
      fault_q <= fault_d;
      blank_q <= blank_d;
    end
  end

  assign drive_o = drive_q;
  assign fault_o = fault_q;
endmodule // sor_channel

// [core/sor_output_module.sv]
// Sixteen-channel output module: cyclic frame, acyclic registers, monitor
// Contract
// - Standard model uses fixed cyclic frame places
// - Acyclic access selects by register number
// - Register 2 / place 0 switches outputs 1-8
// - Register 3 / place 1 switches outputs 9-16
// - Register 30 reports faults 1-8, place 2
// - Register 31 reports faults 9-16, place 3
// - Bus-controller model: switching at places 0,1
// - Bus-controller attachment occupies two digital slots
// - Bits drive channels after sync, under 60us
// - Fault on mismatch; command change clears monitor
// - Any monitor status change raises error
`timescale 1ns/1ps
module sor_output_module
#(
  parameter int unsigned APPLY_CYCLES = sor_pkg::APPLY_CYC
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Function model select
  input  wire logic        model_bc_i,
  // Cyclic frame
  input  wire logic        cyc_wr_i,
  input  wire logic [1:0]  cyc_pos_i,
  input  wire logic [7:0]  cyc_wdata_i,
  input  wire logic [1:0]  cyc_rpos_i,
  output logic      [7:0]  cyc_rdata_o,
  output logic             cyc_rvalid_o,
  // Acyclic register access
  input  wire logic        acy_wr_i,
  input  wire logic        acy_rd_i,
  input  wire logic [7:0]  acy_reg_i,
  input  wire logic [7:0]  acy_wdata_i,
  output logic      [7:0]  acy_rdata_o,
  output logic             acy_ack_o,
  output logic             acy_err_o,
  // Network cycle
  input  wire logic        network_sync_event_i,
  // Channels
  input  wire logic [15:0] sense_i,
  output logic      [15:0] switch_o,
  output logic      [15:0] fault_o,
  output logic             error_msg_o,
  output logic      [1:0]  slot_count_o
);
  localparam int unsigned CW = $clog2(APPLY_CYCLES + 1);

  // Delay must land before the sync limit, so refuse it at elaboration
  if (APPLY_CYCLES < 1 ||
      APPLY_CYCLES * (1000000000 / sor_pkg::CLK_HZ) >= sor_pkg::MAX_DLY_NS)
  begin : g_bad_apply
    $error("APPLY_CYCLES out of range");
  end

  logic [15:0]   shadow_q, shadow_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          pend_q, pend_d;
  logic          apply;
  logic [15:0]   fault_w;
  logic [15:0]   fault_prev_q;
  logic [7:0]    cyc_rdata_d, acy_rdata_d;
  logic          cyc_rvalid_d, acy_ack_d, acy_err_d, err_d;

  // Master writes land in a shadow; channels take it after sync delay
  always_comb
  begin
    shadow_d = shadow_q;
    if (cyc_wr_i)
    begin
      // Both models put switching bytes at places 0 and 1
      if (cyc_pos_i == (model_bc_i ? sor_pkg::BC_POS_SW_LO
                                   : sor_pkg::STD_POS_SW_LO))
        shadow_d[7:0] = cyc_wdata_i;
      else if (cyc_pos_i == (model_bc_i ? sor_pkg::BC_POS_SW_HI
                                        : sor_pkg::STD_POS_SW_HI))
        shadow_d[15:8] = cyc_wdata_i;
    end
    if (acy_wr_i)
    begin
      if (acy_reg_i == sor_pkg::REG_SWITCH_LO)
        shadow_d[7:0] = acy_wdata_i;
      else if (acy_reg_i == sor_pkg::REG_SWITCH_HI)
        shadow_d[15:8] = acy_wdata_i;
    end
  end

  // Fixed delay from sync to channel update
  always_comb
  begin
    cnt_d  = cnt_q;
    pend_d = pend_q;
    apply  = 1'b0;
    if (network_sync_event_i)
    begin
      pend_d = 1'b1;
      cnt_d  = CW'(APPLY_CYCLES - 1);
    end
    else if (pend_q)
    begin
      if (cnt_q == '0)
      begin
        apply  = 1'b1;
        pend_d = 1'b0;
      end
      else
        cnt_d = cnt_q - CW'(1);
    end
  end

  genvar g;
  generate
    for (g = 0; g < sor_pkg::CHANNELS; g++)
    begin : g_ch
      sor_channel u_ch
      (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .apply_i (apply),
        .cmd_i   (shadow_q[g]),
        .sense_i (sense_i[g]),
        .drive_o (switch_o[g]),
        .fault_o (fault_w[g])
      );
    end
  endgenerate

  // Read paths: cyclic by place, acyclic by number
  always_comb
  begin
    cyc_rdata_d  = 8'h00;
    cyc_rvalid_d = 1'b0;
    if (!model_bc_i)
    begin
      // Status has no cyclic place in the bus-controller model
      if (cyc_rpos_i == sor_pkg::STD_POS_FT_LO)
      begin
        cyc_rdata_d  = fault_w[7:0];
        cyc_rvalid_d = 1'b1;
      end
      else if (cyc_rpos_i == sor_pkg::STD_POS_FT_HI)
      begin
        cyc_rdata_d  = fault_w[15:8];
        cyc_rvalid_d = 1'b1;
      end
    end
    acy_rdata_d = 8'h00;
    acy_ack_d   = acy_rd_i | acy_wr_i;
    acy_err_d   = 1'b0;
    if (acy_rd_i)
    begin
      case (acy_reg_i)
        sor_pkg::REG_FAULT_LO: acy_rdata_d = fault_w[7:0];
        sor_pkg::REG_FAULT_HI: acy_rdata_d = fault_w[15:8];
        default:               acy_err_d   = 1'b1;
      endcase
    end
    else if (acy_wr_i)
    begin
      case (acy_reg_i)
        sor_pkg::REG_SWITCH_LO: acy_err_d = 1'b0;
        sor_pkg::REG_SWITCH_HI: acy_err_d = 1'b0;
        default:                acy_err_d = 1'b1;
      endcase
    end
    err_d = (fault_w != fault_prev_q);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shadow_q     <= sor_pkg::SWITCH_RST;
      cnt_q        <= '0;
      pend_q       <= 1'b0;
      fault_prev_q <= sor_pkg::FAULT_RST;
      cyc_rdata_o  <= 8'h00;
      cyc_rvalid_o <= 1'b0;
      acy_rdata_o  <= 8'h00;
      acy_ack_o    <= 1'b0;
      acy_err_o    <= 1'b0;
      error_msg_o  <= 1'b0;
    end
    else
    begin
      shadow_q     <= shadow_d;
      cnt_q        <= cnt_d;
      pend_q       <= pend_d;
      fault_prev_q <= fault_w;
      cyc_rdata_o  <= cyc_rdata_d;
      cyc_rvalid_o <= cyc_rvalid_d;
      acy_rdata_o  <= acy_rdata_d;
      acy_ack_o    <= acy_ack_d;
      acy_err_o    <= acy_err_d;
      error_msg_o  <= err_d;
    end
  end

  assign fault_o      = fault_w;
  assign slot_count_o = model_bc_i ? 2'(sor_pkg::BC_SLOTS) : 2'h0;
endmodule // sor_output_module

// [testbench/sor_output_sva.sv]
// Port assertions for the sixteen-channel output module
`timescale 1ns/1ps
module sor_output_sva
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Requests
  input wire logic        model_bc_i,
  input wire logic [1:0]  cyc_rpos_i,
  input wire logic        acy_wr_i,
  input wire logic        acy_rd_i,
  input wire logic [7:0]  acy_reg_i,
  input wire logic        network_sync_event_i,
  // Answers
  input wire logic [7:0]  cyc_rdata_o,
  input wire logic        cyc_rvalid_o,
  input wire logic [7:0]  acy_rdata_o,
  input wire logic        acy_ack_o,
  input wire logic        acy_err_o,
  input wire logic [15:0] switch_o,
  input wire logic [15:0] fault_o,
  input wire logic        error_msg_o,
  input wire logic [1:0]  slot_count_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_slot_count: assert property (
    slot_count_o == (model_bc_i ? 2'h2 : 2'h0)) else $error("slot count");
  chk_ack_each: assert property (
    (acy_wr_i || acy_rd_i) |=> acy_ack_o) else $error("no ack");
  chk_err_dir: assert property (
    (acy_wr_i && !acy_rd_i && acy_reg_i == sor_pkg::REG_FAULT_LO)
    |=> acy_err_o) else $error("write to status not refused");
  chk_fault_lo: assert property (
    (acy_rd_i && acy_reg_i == sor_pkg::REG_FAULT_LO) |=> !acy_err_o
    && acy_rdata_o == $past(fault_o[7:0])) else $error("reg 30 data");
  chk_cyc_hi: assert property (
    (!model_bc_i && cyc_rpos_i == sor_pkg::STD_POS_FT_HI) |=> cyc_rvalid_o
    && cyc_rdata_o == $past(fault_o[15:8])) else $error("place 3 data");
  chk_bc_nocyc: assert property (
    (model_bc_i && cyc_rpos_i[1]) |=> !cyc_rvalid_o)
    else $error("status place valid in bc model");
  chk_sync_only: assert property (
    !network_sync_event_i [*6] |-> $stable(switch_o))
    else $error("switch changed without sync");
  chk_err_msg: assert property (
    $changed(fault_o) |=> error_msg_o) else $error("no error message");
endmodule // sor_output_sva

// [testbench/sor_load_model.sv]
// Load model: channel lines follow the drive unless a fault is injected
`timescale 1ns/1ps
module sor_load_model
(
  // Drive and injected faults
  input  wire logic [15:0] switch_i,
  input  wire logic [15:0] fault_mask_i,
  // Sensed levels
  output logic      [15:0] sense_o
);
  // Masked channel reads inverted, like a short or external feed
  assign sense_o = switch_i ^ fault_mask_i;
endmodule // sor_load_model

// [testbench/tb_top.sv]
// Self-checking bench for the sixteen-channel output module
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic bc; logic ac; logic [7:0] a;
    logic [7:0] d; logic [15:0] sw;} sor_row_type;
  logic clk_i = 0, rst_i = 1, model_bc_i = 0, cyc_wr_i = 0, acy_wr_i = 0;
  logic acy_rd_i = 0, network_sync_event_i = 0, cyc_rvalid_o, acy_ack_o;
  logic acy_err_o, error_msg_o;
  logic [1:0]  cyc_pos_i = 0, cyc_rpos_i = 0, slot_count_o;
  logic [7:0]  cyc_wdata_i = 0, acy_reg_i = 0, acy_wdata_i = 0;
  logic [7:0]  cyc_rdata_o, acy_rdata_o;
  logic [15:0] sense_i, switch_o, fault_o, mask = 0, prev = 0;
  int          miscompares = 0, cmp_count = 0;
  sor_row_type rows [6] = '{
    '{1'b0, 1'b0, 8'h00, 8'h01, 16'h0001},
    '{1'b0, 1'b0, 8'h01, 8'h80, 16'h8001},
    '{1'b0, 1'b1, 8'h02, 8'h80, 16'h8080},
    '{1'b0, 1'b1, 8'h03, 8'h01, 16'h0180},
    '{1'b0, 1'b0, 8'h02, 8'hFF, 16'h0180},
    '{1'b1, 1'b0, 8'h01, 8'h00, 16'h0080}};
  sor_output_module #(.APPLY_CYCLES(2)) DUT (.clk_i, .rst_i, .model_bc_i,
    .cyc_wr_i, .cyc_pos_i, .cyc_wdata_i, .cyc_rpos_i, .cyc_rdata_o,
    .cyc_rvalid_o, .acy_wr_i, .acy_rd_i, .acy_reg_i, .acy_wdata_i,
    .acy_rdata_o, .acy_ack_o, .acy_err_o, .network_sync_event_i, .sense_i,
    .switch_o, .fault_o, .error_msg_o, .slot_count_o);
  sor_load_model u_load (.switch_i(switch_o), .fault_mask_i(mask),
    .sense_o(sense_i));
  initial forever #12.5 clk_i = ~clk_i;
  task chk(input logic [15:0] s, e, input string n);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task final_report();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Strobes rise 1 ns after an edge and drop after the taking edge
  task acy(input logic w, r, input logic [7:0] a, d);
    @(posedge clk_i) #1 {acy_wr_i, acy_rd_i, acy_reg_i, acy_wdata_i} =
      {w, r, a, d};
    @(posedge clk_i) #1 {acy_wr_i, acy_rd_i} = 2'b00;
  endtask
  task cyc(input logic [1:0] p, input logic [7:0] d);
    @(posedge clk_i) #1 {cyc_wr_i, cyc_pos_i, cyc_wdata_i} = {1'b1, p, d};
    @(posedge clk_i) #1 cyc_wr_i = 0;
  endtask
  task sa(input logic [15:0] o, n);
    @(posedge clk_i) #1 network_sync_event_i = 1;
    @(posedge clk_i) #1 network_sync_event_i = 0;
    @(posedge clk_i) #1 chk(switch_o, o, "switch early");
    @(posedge clk_i) #1 chk(switch_o, n, "switch");
  endtask
  initial
  begin
    #200us miscompares++;
    final_report();
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    #1 rst_i = 0;
    for (int i = 0; i < 6; i++)
    begin
      model_bc_i = rows[i].bc;
      if (rows[i].ac) acy(1'b1, 1'b0, rows[i].a, rows[i].d);
      else cyc(rows[i].a[1:0], rows[i].d);
      sa(prev, rows[i].sw);
      prev = rows[i].sw;
      chk(16'(slot_count_o), {14'h0, rows[i].bc, 1'b0}, "slots");
    end
    model_bc_i = 0;
    mask = 16'h0101;
    repeat (4) @(posedge clk_i);
    #1 chk(fault_o, 16'h0101, "fault");
    acy(1'b0, 1'b1, sor_pkg::REG_FAULT_HI, 8'h00);
    chk({8'h00, acy_rdata_o}, 16'h0001, "reg 31");
    acy(1'b0, 1'b1, sor_pkg::REG_FAULT_LO, 8'h00);
    chk({7'h0, acy_err_o, acy_rdata_o}, 16'h0001, "reg 30");
    cyc_rpos_i = sor_pkg::STD_POS_FT_LO;
    @(posedge clk_i);
    #1 chk({7'h0, cyc_rvalid_o, cyc_rdata_o}, 16'h0101, "place 2");
    cyc_rpos_i = sor_pkg::STD_POS_FT_HI;
    @(posedge clk_i);
    #1 chk({7'h0, cyc_rvalid_o, cyc_rdata_o}, 16'h0101, "place 3");
    model_bc_i = 1;
    @(posedge clk_i);
    #1 chk({7'h0, cyc_rvalid_o, cyc_rdata_o}, 16'h0000, "bc fault");
    model_bc_i = 0;
    acy(1'b1, 1'b0, sor_pkg::REG_FAULT_LO, 8'hFF);
    chk({14'h0, acy_ack_o, acy_err_o}, 16'h0003, "write reg 30");
    acy(1'b0, 1'b1, 8'h05, 8'h00);
    chk({14'h0, acy_ack_o, acy_err_o}, 16'h0003, "unmapped");
    acy(1'b0, 1'b1, sor_pkg::REG_SWITCH_LO, 8'h00);
    chk({14'h0, acy_ack_o, acy_err_o}, 16'h0003, "read of reg 2");
    @(posedge clk_i) #1 rst_i = 1;
    @(posedge clk_i);
    #1 chk(switch_o | fault_o, 16'h0000, "reset state");
    rst_i = 0;
    // Faults still injected, so the monitor trips right after release
    repeat (2) @(posedge clk_i);
    #1 chk({15'h0, error_msg_o}, 16'h0001, "error message");
    chk(fault_o, 16'h0101, "fault after reset");
    cyc(2'h0, 8'h01);
    sa(16'h0000, 16'h0001);
    chk(fault_o, 16'h0100, "fault cleared");
    final_report();
  end
endmodule // tb_top

// Checker on the ports of every output module instance
bind sor_output_module sor_output_sva u_sva (.clk_i, .rst_i, .model_bc_i,
  .cyc_rpos_i, .acy_wr_i, .acy_rd_i, .acy_reg_i, .network_sync_event_i,
  .cyc_rdata_o, .cyc_rvalid_o, .acy_rdata_o, .acy_ack_o, .acy_err_o,
  .switch_o, .fault_o, .error_msg_o, .slot_count_o);
